// ---- shared/sfe_defs.svh ----
// Constants for the serial flash erase, power-down and identifier block.
// Assumes a 20 MHz core clock on both ends of the link.
`ifndef SFE_DEFS_SVH
`define SFE_DEFS_SVH

// Opcodes
`define SFE_OP_WRITE_EN      8'h06
`define SFE_OP_BLOCK_ERASE_A 8'hd8
`define SFE_OP_BLOCK_ERASE_B 8'h52
`define SFE_OP_CHIP_ERASE_A  8'hc7
`define SFE_OP_CHIP_ERASE_B  8'h60
`define SFE_OP_DEEP_SLEEP    8'hb9
`define SFE_OP_RELEASE_ID    8'hab
`define SFE_OP_MFR_DEV_ID    8'h90

// Identifier bytes, values are arbitrary
`define SFE_MFR_ID 8'h5a
`define SFE_DEV_ID 8'h3c

// Frame bit counts
`define SFE_BITS_OPCODE 6'h08
`define SFE_BITS_ADDR   6'h20
`define SFE_BITS_MAX    6'h3f

// Timing in the unit printed, and cycle conversions
`define SFE_CORE_MHZ                 20
`define SFE_DEEP_SLEEP_ENTRY_NS      3000
`define SFE_RELEASE_DELAY_FIRST_NS   3000
`define SFE_RELEASE_DELAY_SECOND_NS  3000
`define SFE_BLOCK_ERASE_DURATION_MS  800
`define SFE_CHIP_ERASE_DURATION_MS   3000
`define SFE_NS_TO_CYC(ns) ((((ns) * `SFE_CORE_MHZ) + 999) / 1000)
`define SFE_MS_TO_CYC(ms) ((ms) * `SFE_CORE_MHZ * 1000)
`define SFE_SCK_HALF_CYC 4

// Host register offsets and fields
`define SFE_REG_CMD        4'h0
`define SFE_REG_ADDR       4'h4
`define SFE_REG_STATUS     4'h8
`define SFE_REG_RDATA      4'hc
`define SFE_CMD_OP_LSB     0
`define SFE_CMD_HDR_LSB    8
`define SFE_CMD_RD_LSB     10

`endif

// ---- shared/sfe_pkg.sv ----
// Types shared by both ends of the serial flash link.
// Assumes sfe_defs.svh holds all numeric constants.
package sfe_pkg;

    typedef enum logic [4:0] {
        PWR_STANDBY     = 5'h01,
        PWR_ERASE       = 5'h02,
        PWR_ENTER_SLEEP = 5'h04,
        PWR_SLEEP       = 5'h08,
        PWR_WAKE        = 5'h10
    } sfe_pwr_type;

    typedef enum logic [3:0] {
        HST_IDLE  = 4'h1,
        HST_SHIFT = 4'h2,
        HST_TAIL  = 4'h4,
        HST_GAP   = 4'h8
    } sfe_hst_type;

endpackage : sfe_pkg

// ---- shared/sfe_if.sv ----
// Serial flash link between the host controller and the flash device.
// Assumes the bench resolves the data output from its enable.
`timescale 1ns/100ps
interface sfe_if;
    logic chip_sel_n;
    logic sclk;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;

    modport flash (
        input  chip_sel_n,
        input  sclk,
        input  serial_in,
        output serial_out,
        output serial_out_oe
    );

    modport host (
        output chip_sel_n,
        output sclk,
        output serial_in,
        input  serial_out,
        input  serial_out_oe
    );
endinterface : sfe_if

// ---- hw/sfe_flash.sv ----
// Flash device end: erase, deep sleep, release and identifier reads.
// Assumes link pins are asynchronous and sampled by core_clk_i;
// the array itself lives outside and obeys the erase pulse.
`timescale 1ns/100ps
`include "sfe_defs.svh"
module sfe_flash
    import sfe_pkg::*;
#(
    parameter int unsigned BLOCK_ERASE_CYC = `SFE_MS_TO_CYC(`SFE_BLOCK_ERASE_DURATION_MS),
    parameter int unsigned CHIP_ERASE_CYC  = `SFE_MS_TO_CYC(`SFE_CHIP_ERASE_DURATION_MS),
    // Arbitrary identifier values
    parameter logic [7:0]  MFR_ID          = `SFE_MFR_ID,
    parameter logic [7:0]  DEV_ID          = `SFE_DEV_ID
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    // Link
    sfe_if.flash            link,
    // Protection straps
    input  wire logic       protect_bit_high_i,
    input  wire logic       protect_bit_low_i,
    // Status
    output logic            write_in_progress_o,
    output logic            write_enable_latch_o,
    output logic            deep_sleep_o,
    // Erase orders to the array
    output logic            erase_req_o,
    output logic            erase_all_o,
    output logic [1:0]      erase_block_o
);

    localparam int unsigned DP_CYC   = `SFE_NS_TO_CYC(`SFE_DEEP_SLEEP_ENTRY_NS);
    localparam int unsigned RES1_CYC = `SFE_NS_TO_CYC(`SFE_RELEASE_DELAY_FIRST_NS);
    localparam int unsigned RES2_CYC = `SFE_NS_TO_CYC(`SFE_RELEASE_DELAY_SECOND_NS);

    logic        cs_s1_ff;
    logic        cs_s2_ff;
    logic        cs_d_ff;
    logic        sclk_s1_ff;
    logic        sclk_s2_ff;
    logic        sclk_d_ff;
    logic        din_s1_ff;
    logic        din_s2_ff;
    logic        armed_ff;
    logic        frame_ok_ff;
    logic [5:0]  bit_cnt_ff;
    logic [30:0] shift_ff;
    logic [7:0]  opcode_ff;
    logic [23:0] addr_ff;
    logic [3:0]  out_idx_ff;
    logic        dout_ff;
    logic        oe_ff;
    logic        wel_ff;
    logic        erase_req_ff;
    logic        erase_all_ff;
    logic [1:0]  erase_block_ff;
    sfe_pwr_type state_ff;
    logic [31:0] timer_ff;

    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        exec_op;
    logic        exec_addr;
    logic        standby;
    logic        write_enable_cmd_go;
    logic        ce_go;
    logic        be_go;
    logic        dp_go;
    logic        rel_go;
    logic        reading;
    logic [7:0]  out_byte;
    logic [1:0]  protect;
    logic        blk_locked;

    // Two-flop synchronisers for the link pins
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_s1_ff   <= 1'b1;
            cs_s2_ff   <= 1'b1;
            cs_d_ff    <= 1'b1;
            sclk_s1_ff <= 1'b0;
            sclk_s2_ff <= 1'b0;
            sclk_d_ff  <= 1'b0;
            din_s1_ff  <= 1'b0;
            din_s2_ff  <= 1'b0;
        end else begin
            cs_s1_ff   <= link.chip_sel_n;
            cs_s2_ff   <= cs_s1_ff;
            cs_d_ff    <= cs_s2_ff;
            sclk_s1_ff <= link.sclk;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_d_ff  <= sclk_s2_ff;
            din_s1_ff  <= link.serial_in;
            din_s2_ff  <= din_s1_ff;
        end
    end

    assign sclk_rise = ~cs_s2_ff & sclk_s2_ff & ~sclk_d_ff;
    assign sclk_fall = ~cs_s2_ff & ~sclk_s2_ff & sclk_d_ff;
    assign cs_fall   = ~cs_s2_ff & cs_d_ff;
    assign cs_rise   = cs_s2_ff & ~cs_d_ff;

    // Select must be seen high after reset before a frame counts
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_ff    <= 1'b0;
            frame_ok_ff <= 1'b0;
        end else begin
            armed_ff <= armed_ff | cs_s2_ff;
            if (cs_fall) begin
                frame_ok_ff <= armed_ff;
            end
        end
    end

    // Shift in opcode and address on rising clock edges
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_ff <= 6'h00;
            shift_ff   <= 31'h0;
            opcode_ff  <= 8'h00;
            addr_ff    <= 24'h000000;
        end else if (cs_fall) begin
            bit_cnt_ff <= 6'h00;
        end else if (sclk_rise) begin
            shift_ff <= {shift_ff[29:0], din_s2_ff};
            if (bit_cnt_ff != `SFE_BITS_MAX) begin
                bit_cnt_ff <= bit_cnt_ff + 6'h01;
            end
            if (bit_cnt_ff == `SFE_BITS_OPCODE - 6'h01) begin
                opcode_ff <= {shift_ff[6:0], din_s2_ff};
            end
            if (bit_cnt_ff == `SFE_BITS_ADDR - 6'h01) begin
                addr_ff <= {shift_ff[22:0], din_s2_ff};
            end
        end
    end

    assign standby   = (state_ff == PWR_STANDBY);
    assign protect   = {protect_bit_high_i, protect_bit_low_i};
    // frame must end exactly after the 8 opcode bits or the 32 address bits
    assign exec_op   = cs_rise & frame_ok_ff & (bit_cnt_ff == `SFE_BITS_OPCODE);
    assign exec_addr = cs_rise & frame_ok_ff & (bit_cnt_ff == `SFE_BITS_ADDR);

    // upper blocks locked first, all when both set
    always_comb begin
        unique case (protect)
            2'h0: blk_locked = 1'b0;
            2'h1: blk_locked = (addr_ff[17:16] == 2'h3);
            2'h2: blk_locked = addr_ff[17];
            2'h3: blk_locked = 1'b1;
        endcase
    end

    // every order below except release needs idle standby
    assign write_enable_cmd_go = exec_op & standby & (opcode_ff == `SFE_OP_WRITE_EN);
    assign ce_go   = exec_op & standby & wel_ff & (protect == 2'h0)
                   & ((opcode_ff == `SFE_OP_CHIP_ERASE_A) | (opcode_ff == `SFE_OP_CHIP_ERASE_B));
    assign be_go   = exec_addr & standby & wel_ff & ~blk_locked
                   & ((opcode_ff == `SFE_OP_BLOCK_ERASE_A) | (opcode_ff == `SFE_OP_BLOCK_ERASE_B));
    // deep sleep accepted only when idle
    assign dp_go   = exec_op & standby & (opcode_ff == `SFE_OP_DEEP_SLEEP);
    // only release wakes a sleeping device
    assign rel_go  = cs_rise & frame_ok_ff & (state_ff == PWR_SLEEP)
                   & (bit_cnt_ff >= `SFE_BITS_OPCODE) & (opcode_ff == `SFE_OP_RELEASE_ID);

    // Power and erase sequencing
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= PWR_STANDBY;
            timer_ff <= 32'h0;
        end else begin
            unique case (state_ff)
                PWR_STANDBY: begin
                    // self-timed cycle starts on select rise
                    if (ce_go) begin
                        state_ff <= PWR_ERASE;
                        timer_ff <= 32'(CHIP_ERASE_CYC - 1);
                    end else if (be_go) begin
                        state_ff <= PWR_ERASE;
                        timer_ff <= 32'(BLOCK_ERASE_CYC - 1);
                    end else if (dp_go) begin
                        state_ff <= PWR_ENTER_SLEEP;
                        timer_ff <= 32'(DP_CYC - 1);
                    end
                end
                PWR_ERASE, PWR_ENTER_SLEEP, PWR_WAKE: begin
                    if (timer_ff == 32'h0) begin
                        state_ff <= (state_ff == PWR_ENTER_SLEEP) ? PWR_SLEEP : PWR_STANDBY;
                    end else begin
                        timer_ff <= timer_ff - 32'h1;
                    end
                end
                PWR_SLEEP: begin
                    if (rel_go) begin
                        state_ff <= PWR_WAKE;
                        // opcode alone wakes after first delay
                        timer_ff <= (bit_cnt_ff == `SFE_BITS_OPCODE) ? 32'(RES1_CYC - 1)
                                                                     : 32'(RES2_CYC - 1);
                    end
                end
                default: begin
                    state_ff <= PWR_STANDBY;
                    timer_ff <= 32'h0;
                end
            endcase
        end
    end

    // Write-enable latch
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wel_ff <= 1'b0;
        end else if (write_enable_cmd_go) begin
            wel_ff <= 1'b1;
        // latch clears as the cycle starts
        end else if (ce_go | be_go) begin
            wel_ff <= 1'b0;
        end
    end

    // erase order to the array, one pulse per accepted erase
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            erase_req_ff   <= 1'b0;
            erase_all_ff   <= 1'b0;
            erase_block_ff <= 2'h0;
        end else begin
            erase_req_ff <= ce_go | be_go;
            if (ce_go | be_go) begin
                erase_all_ff   <= ce_go;
                erase_block_ff <= addr_ff[17:16];
            end
        end
    end

    // identifier output only awake and idle
    assign reading = frame_ok_ff & standby & (bit_cnt_ff >= `SFE_BITS_ADDR)
                   & ((opcode_ff == `SFE_OP_RELEASE_ID) | (opcode_ff == `SFE_OP_MFR_DEV_ID));

    // byte choice for the identifier stream
    always_comb begin
        if (opcode_ff == `SFE_OP_RELEASE_ID) begin
            out_byte = DEV_ID;
        end else if (out_idx_ff[3] ^ addr_ff[0]) begin
            out_byte = DEV_ID;
        end else begin
            out_byte = MFR_ID;
        end
    end

    // shift out most significant bit first on falling edges
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_idx_ff <= 4'h0;
            dout_ff    <= 1'b0;
            oe_ff      <= 1'b0;
        end else if (cs_s2_ff) begin
            out_idx_ff <= 4'h0;
            oe_ff      <= 1'b0;
        end else if (sclk_fall & reading) begin
            out_idx_ff <= out_idx_ff + 4'h1;
            dout_ff    <= out_byte[3'h7 - out_idx_ff[2:0]];
            oe_ff      <= 1'b1;
        end
    end

    assign link.serial_out      = dout_ff;
    assign link.serial_out_oe   = oe_ff;
    // busy flag follows the erase state
    assign write_in_progress_o  = (state_ff == PWR_ERASE);
    assign write_enable_latch_o = wel_ff;
    assign deep_sleep_o         = (state_ff == PWR_SLEEP);
    assign erase_req_o          = erase_req_ff;
    assign erase_all_o          = erase_all_ff;
    assign erase_block_o        = erase_block_ff;

endmodule : sfe_flash

// ---- hw/sfe_host.sv ----
// Host controller end: runs one framed transfer per command write.
// Assumes software sets opcode, header and read byte counts itself.
`timescale 1ns/100ps
`include "sfe_defs.svh"
module sfe_host
    import sfe_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    output logic             busy_o,
    // Link
    sfe_if.host              link
);

    localparam int unsigned GAP_CYC = `SFE_NS_TO_CYC(`SFE_RELEASE_DELAY_SECOND_NS);

    sfe_hst_type state_ff;
    logic [2:0]  div_ff;
    logic        tick;
    logic        cs_n_ff;
    logic        sclk_ff;
    logic        mosi_ff;
    logic [31:0] tx_ff;
    logic [5:0]  bit_idx_ff;
    logic [5:0]  total_ff;
    logic [5:0]  first_rx_ff;
    logic [15:0] rx_ff;
    logic [23:0] addr_reg_ff;
    logic [31:0] gap_ff;
    logic [31:0] rdata_ff;
    logic        miso_s1_ff;
    logic        miso_s2_ff;
    logic        start;

    // Half-period enable for the link clock
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_ff <= 3'h0;
        end else if (tick) begin
            div_ff <= 3'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end
    assign tick = (div_ff == 3'(`SFE_SCK_HALF_CYC - 1));

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            miso_s1_ff <= 1'b0;
            miso_s2_ff <= 1'b0;
        end else begin
            miso_s1_ff <= link.serial_out;
            miso_s2_ff <= miso_s1_ff;
        end
    end

    assign start = wr_i & (addr_i == `SFE_REG_CMD) & (state_ff == HST_IDLE);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_reg_ff <= 24'h000000;
        end else if (wr_i & (addr_i == `SFE_REG_ADDR)) begin
            addr_reg_ff <= wdata_i[23:0];
        end
    end

    // Frame sequencing
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff    <= HST_IDLE;
            cs_n_ff     <= 1'b1;
            sclk_ff     <= 1'b0;
            mosi_ff     <= 1'b0;
            tx_ff       <= 32'h0;
            bit_idx_ff  <= 6'h00;
            total_ff    <= 6'h00;
            first_rx_ff <= 6'h00;
            rx_ff       <= 16'h0000;
            gap_ff      <= 32'h0;
        end else begin
            unique case (state_ff)
                HST_IDLE: begin
                    if (start) begin
                        tx_ff       <= {wdata_i[`SFE_CMD_OP_LSB +: 8], addr_reg_ff};
                        mosi_ff     <= wdata_i[`SFE_CMD_OP_LSB + 7];
                        first_rx_ff <= 6'h08 + {1'b0, wdata_i[`SFE_CMD_HDR_LSB +: 2], 3'h0};
                        total_ff    <= 6'h08 + {1'b0, wdata_i[`SFE_CMD_HDR_LSB +: 2], 3'h0}
                                     + {1'b0, wdata_i[`SFE_CMD_RD_LSB +: 2], 3'h0};
                        bit_idx_ff  <= 6'h00;
                        rx_ff       <= 16'h0000;
                        // select held low across the whole frame
                        cs_n_ff     <= 1'b0;
                        state_ff    <= HST_SHIFT;
                    end
                end
                HST_SHIFT: begin
                    if (tick & ~sclk_ff) begin
                        sclk_ff <= 1'b1;
                    end else if (tick) begin
                        if (bit_idx_ff >= first_rx_ff) begin
                            rx_ff <= {rx_ff[14:0], miso_s2_ff};
                        end
                        sclk_ff    <= 1'b0;
                        tx_ff      <= {tx_ff[30:0], 1'b0};
                        mosi_ff    <= tx_ff[30];
                        bit_idx_ff <= bit_idx_ff + 6'h01;
                        if (bit_idx_ff + 6'h01 == total_ff) begin
                            state_ff <= HST_TAIL;
                        end
                    end
                end
                HST_TAIL: begin
                    // select rises one half period after the last clock fall
                    if (tick) begin
                        cs_n_ff  <= 1'b1;
                        gap_ff   <= 32'(GAP_CYC - 1);
                        state_ff <= HST_GAP;
                    end
                end
                HST_GAP: begin
                    // select held high for the release delay
                    if (gap_ff == 32'h0) begin
                        state_ff <= HST_IDLE;
                    end else begin
                        gap_ff <= gap_ff - 32'h1;
                    end
                end
                default: begin
                    state_ff <= HST_IDLE;
                    cs_n_ff  <= 1'b1;
                end
            endcase
        end
    end

    // Register reads, answered the next cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h0;
        end else if (rd_i) begin
            unique case (addr_i)
                `SFE_REG_ADDR:   rdata_ff <= {8'h00, addr_reg_ff};
                `SFE_REG_STATUS: rdata_ff <= {31'h0, state_ff != HST_IDLE};
                `SFE_REG_RDATA:  rdata_ff <= {16'h0000, rx_ff};
                default:         rdata_ff <= 32'h0;
            endcase
        end
    end

    assign rdata_o         = rdata_ff;
    assign busy_o          = (state_ff != HST_IDLE);
    assign link.chip_sel_n = cs_n_ff;
    assign link.sclk       = sclk_ff;
    assign link.serial_in  = mosi_ff;

endmodule : sfe_host

// ---- dv/sfe_monitor.sv ----
// Checker on the wires between host and flash ends.
// Assumes one core clock domain and an async high reset.
`timescale 1ns/100ps
module sfe_monitor (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Link
    input wire logic chip_sel_n,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic [7:0] hi_cnt_ff;
    logic [7:0] pulses_ff;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Cycles spent deselected, saturating
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) hi_cnt_ff <= 8'hff;
        else if (!chip_sel_n) hi_cnt_ff <= 8'h00;
        else if (hi_cnt_ff != 8'hff) hi_cnt_ff <= hi_cnt_ff + 8'h01;
    end

    // Link clock rises within the current frame
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) pulses_ff <= 8'h00;
        else if (chip_sel_n) pulses_ff <= 8'h00;
        else if ($rose(sclk)) pulses_ff <= pulses_ff + 8'h01;
    end

    frame_whole_a: assert property ($rose(chip_sel_n) |-> pulses_ff[2:0] == 3'h0)
        else $error("frame not a whole number of bytes");
    sel_gap_a: assert property ($fell(chip_sel_n) |-> hi_cnt_ff >= 8'd60)
        else $error("select high gap too short");
    clk_idle_a: assert property (chip_sel_n && $past(chip_sel_n) |-> !sclk)
        else $error("link clock moves while deselected");
    clk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("link clock high phase wrong");
    clk_low_a: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("link clock low phase short");
    din_hold_a: assert property (sclk && $past(sclk) |-> $stable(serial_in))
        else $error("input data moved while clock high");
    dout_hold_a: assert property (sclk && $past(sclk) && serial_out_oe |-> $stable(serial_out))
        else $error("output data moved while clock high");
    out_late_a: assert property ($rose(serial_out_oe) |-> pulses_ff >= 8'd32)
        else $error("output driven before header done");
    out_off_a: assert property (chip_sel_n [*4] |-> !serial_out_oe)
        else $error("output driven while deselected");

    cover property ($rose(serial_out_oe));
    cover property ($rose(chip_sel_n) && pulses_ff == 8'd32);
    cover property ($rose(chip_sel_n) && pulses_ff == 8'd8);
endmodule : sfe_monitor

// ---- dv/tb_top.sv ----
// Bench joining host and flash ends over the link interface.
// Assumes shortened erase counts and a 20 MHz core clock.
`timescale 1ns/100ps
`include "sfe_defs.svh"
module tb_top;
    logic        core_clk_i = 1'b0;
    logic        rst_i      = 1'b1;
    logic [3:0]  addr_i     = 4'h0;
    logic [31:0] wdata_i    = 32'h0;
    logic        wr_i       = 1'b0;
    logic        rd_i       = 1'b0;
    logic        prot_hi    = 1'b0;
    logic        prot_lo    = 1'b0;
    logic [31:0] rdata_o;
    logic        busy_o;
    logic        write_in_progress_flag;
    logic        write_enable_latch;
    logic        sleep;
    logic        eall;
    logic [1:0]  eblk;
    logic        ereq;
    logic [31:0] d;
    int          n_fail = 0;
    int          checks = 0;
    int          n_erase = 0;

    sfe_if link ();

    sfe_flash #(.BLOCK_ERASE_CYC(200), .CHIP_ERASE_CYC(400)) i_sfe_flash (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .link(link.flash),
        .protect_bit_high_i(prot_hi), .protect_bit_low_i(prot_lo),
        .write_in_progress_o(write_in_progress_flag), .write_enable_latch_o(write_enable_latch), .deep_sleep_o(sleep),
        .erase_req_o(ereq), .erase_all_o(eall), .erase_block_o(eblk));
    sfe_host i_sfe_host (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o), .link(link.host));
    sfe_monitor i_sfe_monitor (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .chip_sel_n(link.chip_sel_n), .sclk(link.sclk),
        .serial_in(link.serial_in), .serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe));

    always #25 core_clk_i = ~core_clk_i;

    // Erase orders handed to the array
    always @(posedge core_clk_i) begin
        if (ereq === 1'b1) n_erase <= n_erase + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge core_clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    // One framed transfer, then wait out busy and the select gap
    task automatic cmd(input logic [7:0] op, input logic [1:0] hdr, input logic [1:0] nrd,
                       input logic [23:0] a);
        int n;
        n = 0;
        wr(`SFE_REG_ADDR, {8'h00, a});
        wr(`SFE_REG_CMD, {20'h0, nrd, hdr, op});
        repeat (2) @(negedge core_clk_i);
        while (busy_o !== 1'b0 && n < 2000) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n >= 2000) n_fail++;
        repeat (4) @(negedge core_clk_i);
    endtask : cmd

    task automatic write_enable_cmd();
        cmd(`SFE_OP_WRITE_EN, 2'd0, 2'd0, 24'h0);
    endtask : write_enable_cmd

    task automatic wait_idle();
        int n;
        n = 0;
        while (write_in_progress_flag !== 1'b0 && n < 1000) begin
            @(negedge core_clk_i);
            n++;
        end
        check(write_in_progress_flag, 1'b0);
    endtask : wait_idle

    task automatic t_reset();
        check(sleep, 1'b0);
        rd(4'h2);
        check(d, 32'h0);
        rd(`SFE_REG_STATUS);
        check(d[0], 1'b0);
    endtask : t_reset

    task automatic t_chip();
        cmd(`SFE_OP_CHIP_ERASE_A, 2'd0, 2'd0, 24'h0);
        check(write_in_progress_flag, 1'b0);
        write_enable_cmd();
        check(write_enable_latch, 1'b1);
        @(posedge core_clk_i) prot_lo <= 1'b1;
        cmd(`SFE_OP_CHIP_ERASE_A, 2'd0, 2'd0, 24'h0);
        check(write_in_progress_flag, 1'b0);
        @(posedge core_clk_i) prot_lo <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            write_enable_cmd();
            cmd(i ? `SFE_OP_CHIP_ERASE_B : `SFE_OP_CHIP_ERASE_A, 2'd0, 2'd0, 24'h0);
            check(write_in_progress_flag, 1'b1);
            check(write_enable_latch, 1'b0);
            check(eall, 1'b1);
            cmd(`SFE_OP_DEEP_SLEEP, 2'd0, 2'd0, 24'h0);
            check(sleep, 1'b0);
            check(write_in_progress_flag, 1'b1);
            wait_idle();
        end
        check(n_erase, 2);
    endtask : t_chip

    task automatic t_block();
        @(posedge core_clk_i) prot_hi <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            write_enable_cmd();
            cmd(i ? `SFE_OP_BLOCK_ERASE_B : `SFE_OP_BLOCK_ERASE_A, 2'd3, 2'd0, 24'h01a5c3);
            check(write_in_progress_flag, 1'b1);
            check({eall, eblk}, 3'h1);
            wait_idle();
        end
        write_enable_cmd();
        cmd(`SFE_OP_BLOCK_ERASE_A, 2'd3, 2'd0, 24'h030000);
        check(write_in_progress_flag, 1'b0);
        write_enable_cmd();
        cmd(`SFE_OP_BLOCK_ERASE_A, 2'd2, 2'd0, 24'h000100);
        check(write_in_progress_flag, 1'b0);
        check(n_erase, 4);
        @(posedge core_clk_i) prot_hi <= 1'b0;
    endtask : t_block

    task automatic t_ids();
        cmd(`SFE_OP_MFR_DEV_ID, 2'd3, 2'd2, 24'h000000);
        rd(`SFE_REG_RDATA);
        check(d[15:0], {`SFE_MFR_ID, `SFE_DEV_ID});
        cmd(`SFE_OP_MFR_DEV_ID, 2'd3, 2'd2, 24'h000001);
        rd(`SFE_REG_RDATA);
        check(d[15:0], {`SFE_DEV_ID, `SFE_MFR_ID});
        cmd(`SFE_OP_RELEASE_ID, 2'd3, 2'd2, 24'h000000);
        rd(`SFE_REG_RDATA);
        check(d[15:0], {`SFE_DEV_ID, `SFE_DEV_ID});
    endtask : t_ids

    task automatic t_sleep();
        for (int i = 0; i < 2; i++) begin
            // Erase first so the latch is clear before sleeping
            write_enable_cmd();
            cmd(`SFE_OP_CHIP_ERASE_B, 2'd0, 2'd0, 24'h0);
            wait_idle();
            check(write_enable_latch, 1'b0);
            cmd(`SFE_OP_DEEP_SLEEP, 2'd0, 2'd0, 24'h0);
            check(sleep, 1'b1);
            write_enable_cmd();
            check(write_enable_latch, 1'b0);
            cmd(`SFE_OP_RELEASE_ID, i ? 2'd3 : 2'd0, 2'd0, 24'h0);
            check(sleep, 1'b0);
            write_enable_cmd();
            check(write_enable_latch, 1'b1);
        end
        check(n_erase, 6);
    endtask : t_sleep

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_chip();
        t_block();
        t_ids();
        t_sleep();
        close_out();
    end

    initial begin
        repeat (30000) @(posedge core_clk_i);
        n_fail++;
        close_out();
    end
endmodule : tb_top
